//--- hdl/xor_nibble_exec.sv
// Execution unit for the xor group and the low-nibble exchange, with register-bus access
//
// Functional notes
// - Nibble swap exchanges low nibbles only
// - Nibble swap: one byte, bit0 selects pointer
// - Xor immediate into accumulator, two bytes
// - Xor indirect into accumulator, bit0 selects pointer
// - Xor working register into accumulator
// - Xor direct byte into accumulator
// - Xor immediate into memory, three bytes, two cycles
// - Address 90H is the first port
// - Parity bit tracks accumulator odd ones
// - Port source reads the input pins
// - Port read-modify-write uses the latch
// - Pointer at 128 or more: undefined, lost
`timescale 1ns/1ps
`default_nettype none

module xor_nibble_exec #(
   parameter int ADDR_W = 8,    // Decoded register-bus address bits
   parameter int RAM_DEPTH = 128 // Internal memory bytes
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Register bus, write address and data
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // Register bus, write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Register bus, read
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // First I/O port
   input wire logic [7:0] port_pins,
   output logic [7:0] port_out
);

   initial begin
      if (ADDR_W < 8 || ADDR_W > 32 || RAM_DEPTH != 128) begin
         $error("xor_nibble_exec: unsupported parameter values");
      end
   end

   // ---------------------------------------------------------------
   // Architectural state
   // ---------------------------------------------------------------
   logic [7:0] ram [RAM_DEPTH]; // Internal memory, working registers in the low 32 bytes
   logic [7:0] acc;             // Accumulator
   logic [7:1] flag_bits; // Stored status word bits, parity is derived
   logic [7:0] port_latch;      // Output latch of the first port
   logic [6:0] mem_addr;        // Memory window pointer for software
   logic illegal;               // Sticky illegal opcode flag
   xor_nibble_pkg::instr_s ins; // Instruction being executed
   xor_nibble_pkg::exec_state_e state;
   logic [7:0] program_status_word;

   // Parity is never stored, so it cannot disagree with the accumulator
   assign program_status_word = {flag_bits, ^acc};

   // ---------------------------------------------------------------
   // Direct-address read
   // ---------------------------------------------------------------
   // Port reads pick pins or latch; the caller says which
   function automatic logic [7:0] dir_read(input logic [7:0] a, input logic use_latch);
      logic [7:0] v;
      v = 8'h00;
      if (a < xor_nibble_pkg::SFR_BASE) begin
         v = ram[a[6:0]];
      end else if (a == xor_nibble_pkg::ADDR_PORT0) begin
         v = use_latch ? port_latch : port_pins;
      end else if (a == xor_nibble_pkg::ADDR_ACC) begin
         v = acc;
      end else if (a == xor_nibble_pkg::ADDR_STATUS) begin
         v = program_status_word;
      end
      return v;
   endfunction

   // ---------------------------------------------------------------
   // Operand fetch
   // ---------------------------------------------------------------
   logic [1:0] bank;        // Selected register bank
   logic [7:0] pointer;     // Indirect pointer register contents
   logic ind_ok;            // Pointer inside internal memory
   logic [7:0] ind_val;     // Indirect operand
   logic [7:0] work_reg_val; // Working register operand

   always_comb begin
      bank = {flag_bits[xor_nibble_pkg::BANK_HI_BIT], flag_bits[xor_nibble_pkg::BANK_LO_BIT]};
      pointer = ram[{2'b00, bank, 2'b00, ins.opcode[0]}];
      ind_ok = (pointer < xor_nibble_pkg::SFR_BASE);
      // Out-of-range pointer gives undefined data, timing is unchanged
      ind_val = ind_ok ? ram[pointer[6:0]] : xor_nibble_pkg::UNDEF_DATA;
      work_reg_val = ram[{2'b00, bank, ins.opcode[2:0]}];
   end

   // ---------------------------------------------------------------
   // Execute: decode and next values
   // ---------------------------------------------------------------
   logic acc_wr;            // Execution writes the accumulator
   logic [7:0] next_acc;
   logic dir_wr;            // Execution writes a direct address
   logic [7:0] dir_wa;
   logic [7:0] dir_wd;
   logic two_cycle;         // Opcode needs a second cycle
   logic bad_op;            // Opcode not served here

   always_comb begin
      acc_wr = 1'b0;
      next_acc = acc;
      dir_wr = 1'b0;
      dir_wa = ins.operand1;
      dir_wd = 8'h00;
      two_cycle = (ins.opcode == xor_nibble_pkg::OP_XOR_DIR_IMM);
      bad_op = 1'b0;
      if (ins.opcode[7:1] == xor_nibble_pkg::OP_NIBBLE_SWAP_HI) begin
         // Upper nibbles stay, lower nibbles trade places
         acc_wr = 1'b1;
         next_acc = {acc[7:4], ind_val[3:0]};
         dir_wr = ind_ok;
         dir_wa = pointer;
         dir_wd = {ind_val[7:4], acc[3:0]};
      end else if (ins.opcode == xor_nibble_pkg::OP_XOR_IMM) begin
         acc_wr = 1'b1;
         next_acc = acc ^ ins.operand1;
      end else if (ins.opcode[7:1] == xor_nibble_pkg::OP_XOR_IND_HI) begin
         acc_wr = 1'b1;
         next_acc = acc ^ ind_val;
      end else if (ins.opcode[7:3] == xor_nibble_pkg::OP_XOR_REG_HI) begin
         acc_wr = 1'b1;
         next_acc = acc ^ work_reg_val;
      end else if (ins.opcode == xor_nibble_pkg::OP_XOR_DIR) begin
         acc_wr = 1'b1;
         next_acc = acc ^ dir_read(ins.operand1, 1'b0);
      end else if (ins.opcode == xor_nibble_pkg::OP_XOR_DIR_ACC) begin
         dir_wr = 1'b1;
         dir_wd = dir_read(ins.operand1, 1'b1) ^ acc;
      end else if (two_cycle) begin
         // Write lands in the second cycle only
         dir_wr = (state == xor_nibble_pkg::ST_EXEC2);
         dir_wd = dir_read(ins.operand1, 1'b1) ^ ins.operand2;
      end else begin
         bad_op = 1'b1;
      end
      // Only a finishing cycle commits anything
      if (state == xor_nibble_pkg::ST_IDLE || (two_cycle && state == xor_nibble_pkg::ST_EXEC)) begin
         acc_wr = 1'b0;
         dir_wr = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Register bus decode
   // ---------------------------------------------------------------
   logic busy;
   logic wr_take;           // Address and data taken together
   logic rd_take;
   logic [ADDR_W-1:0] wa;
   logic wr_mapped;
   logic wr_ok;             // Write accepted and applied
   logic [7:0] wb0;         // Write data lane 0, masked by its strobe

   assign busy = (state != xor_nibble_pkg::ST_IDLE);
   // Both channels are required at once; a lone channel simply waits
   assign wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_take;
   assign s_axi_wready = wr_take;
   assign rd_take = s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wa = s_axi_awaddr[ADDR_W-1:0];
   assign wb0 = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      return a == ADDR_W'(xor_nibble_pkg::REG_INSTR) || a == ADDR_W'(xor_nibble_pkg::REG_ACC)
         || a == ADDR_W'(xor_nibble_pkg::REG_STATUS_WORD)
         || a == ADDR_W'(xor_nibble_pkg::REG_PORT_LATCH)
         || a == ADDR_W'(xor_nibble_pkg::REG_MEM_ADDR)
         || a == ADDR_W'(xor_nibble_pkg::REG_MEM_DATA)
         || a == ADDR_W'(xor_nibble_pkg::REG_EXEC_STATUS);
   endfunction

   // State-changing writes are refused while an instruction runs
   assign wr_mapped = is_mapped(wa);
   assign wr_ok = wr_take && wr_mapped && !busy;

   function automatic logic sw_hit(input logic [7:0] r);
      return wr_ok && wa == ADDR_W'(r);
   endfunction

   // ---------------------------------------------------------------
   // Control sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state <= xor_nibble_pkg::ST_IDLE;
      end else begin
         unique case (state)
            xor_nibble_pkg::ST_IDLE: begin
               if (sw_hit(xor_nibble_pkg::REG_INSTR)) begin
                  state <= xor_nibble_pkg::ST_EXEC;
               end
            end
            xor_nibble_pkg::ST_EXEC: begin
               state <= two_cycle ? xor_nibble_pkg::ST_EXEC2 : xor_nibble_pkg::ST_IDLE;
            end
            xor_nibble_pkg::ST_EXEC2: begin
               state <= xor_nibble_pkg::ST_IDLE;
            end
            default: begin
               state <= xor_nibble_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Instruction bytes, captured when software issues one
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ins <= '0;
      end else if (sw_hit(xor_nibble_pkg::REG_INSTR)) begin
         ins <= {s_axi_wstrb[2] ? s_axi_wdata[23:16] : 8'h00,
                 s_axi_wstrb[1] ? s_axi_wdata[15:8] : 8'h00, wb0};
      end
   end

   // Illegal opcode flag: set wins over a write-one clear
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         illegal <= 1'b0;
      end else if (state == xor_nibble_pkg::ST_EXEC && bad_op) begin
         illegal <= 1'b1;
      end else if (sw_hit(xor_nibble_pkg::REG_EXEC_STATUS) && wb0[xor_nibble_pkg::ILLEGAL_BIT]) begin
         illegal <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Datapath registers
   // ---------------------------------------------------------------
   // Accumulator, from execution or software
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         acc <= xor_nibble_pkg::ACC_RESET;
      end else if (dir_wr && dir_wa == xor_nibble_pkg::ADDR_ACC) begin
         acc <= dir_wd;
      end else if (acc_wr) begin
         acc <= next_acc;
      end else if (sw_hit(xor_nibble_pkg::REG_ACC)) begin
         acc <= wb0;
      end
   end

   // Status word: flags change only on an explicit write to its address
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         flag_bits <= xor_nibble_pkg::STATUS_RESET[7:1];
      end else if (dir_wr && dir_wa == xor_nibble_pkg::ADDR_STATUS) begin
         flag_bits <= dir_wd[7:1];
      end else if (sw_hit(xor_nibble_pkg::REG_STATUS_WORD)) begin
         flag_bits <= wb0[7:1];
      end
   end

   // Port latch, reached at its direct address
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         port_latch <= xor_nibble_pkg::LATCH_RESET;
      end else if (dir_wr && dir_wa == xor_nibble_pkg::ADDR_PORT0) begin
         port_latch <= dir_wd;
      end else if (sw_hit(xor_nibble_pkg::REG_PORT_LATCH)) begin
         port_latch <= wb0;
      end
   end
   assign port_out = port_latch;

   // Memory window pointer
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         mem_addr <= '0;
      end else if (sw_hit(xor_nibble_pkg::REG_MEM_ADDR)) begin
         mem_addr <= wb0[6:0];
      end
   end

   // Internal memory has no reset, as real RAM would not
   always_ff @(posedge core_clk) begin
      if (dir_wr && dir_wa < xor_nibble_pkg::SFR_BASE) begin
         ram[dir_wa[6:0]] <= dir_wd;
      end else if (sw_hit(xor_nibble_pkg::REG_MEM_DATA)) begin
         ram[mem_addr] <= wb0;
      end
   end

   // ---------------------------------------------------------------
   // Bus responses
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= xor_nibble_pkg::RESP_OKAY;
      end else if (wr_take) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? xor_nibble_pkg::RESP_OKAY : xor_nibble_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   logic [ADDR_W-1:0] ra;
   logic [7:0] rd_byte;
   assign ra = s_axi_araddr[ADDR_W-1:0];

   // Read mux, low byte only; upper bits read zero
   always_comb begin
      rd_byte = 8'h00;
      unique case (ra)
         ADDR_W'(xor_nibble_pkg::REG_INSTR): rd_byte = ins.opcode;
         ADDR_W'(xor_nibble_pkg::REG_ACC): rd_byte = acc;
         ADDR_W'(xor_nibble_pkg::REG_STATUS_WORD): rd_byte = program_status_word;
         ADDR_W'(xor_nibble_pkg::REG_PORT_LATCH): rd_byte = port_latch;
         ADDR_W'(xor_nibble_pkg::REG_MEM_ADDR): rd_byte = {1'b0, mem_addr};
         ADDR_W'(xor_nibble_pkg::REG_MEM_DATA): rd_byte = ram[mem_addr];
         ADDR_W'(xor_nibble_pkg::REG_EXEC_STATUS): rd_byte = {6'h00, illegal, busy};
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= xor_nibble_pkg::RESP_OKAY;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, rd_byte};
         s_axi_rresp <= is_mapped(ra) ? xor_nibble_pkg::RESP_OKAY : xor_nibble_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   logic fin;
   assign fin = (state == xor_nibble_pkg::ST_EXEC) && !two_cycle;

   // Checked where software sees it, so a broken read path is caught too
   parity_track_a: assert property (rd_take && ra == ADDR_W'(xor_nibble_pkg::REG_STATUS_WORD)
      |=> s_axi_rdata[xor_nibble_pkg::PARITY_BIT] == $past(^acc))
      else $error("parity wrong");
   swap_nibble_a: assert property (fin && ins.opcode[7:1] == xor_nibble_pkg::OP_NIBBLE_SWAP_HI
      |=> acc == {$past(acc[7:4]), $past(ind_val[3:0])}) else $error("swap wrong");
   xor_imm_a: assert property (fin && ins.opcode == xor_nibble_pkg::OP_XOR_IMM
      |=> acc == ($past(acc) ^ $past(ins.operand1))) else $error("xor imm wrong");
   xor_ind_a: assert property (fin && ins.opcode[7:1] == xor_nibble_pkg::OP_XOR_IND_HI
      |=> acc == ($past(acc) ^ $past(ind_val))) else $error("xor ind wrong");
   xor_reg_a: assert property (fin && ins.opcode[7:3] == xor_nibble_pkg::OP_XOR_REG_HI
      |=> acc == ($past(acc) ^ $past(work_reg_val))) else $error("xor reg wrong");
   pin_source_a: assert property (fin && ins.opcode == xor_nibble_pkg::OP_XOR_DIR
      && ins.operand1 == xor_nibble_pkg::ADDR_PORT0
      |=> acc == ($past(acc) ^ $past(port_pins))) else $error("pins not read");
   two_cycle_a: assert property ($rose(state == xor_nibble_pkg::ST_EXEC) && two_cycle
      |=> state == xor_nibble_pkg::ST_EXEC2 ##1 state == xor_nibble_pkg::ST_IDLE)
      else $error("two cycle timing");
   port_rmw_a: assert property (state == xor_nibble_pkg::ST_EXEC2
      && ins.operand1 == xor_nibble_pkg::ADDR_PORT0
      |=> port_out == ($past(port_latch) ^ $past(ins.operand2))) else $error("port rmw");
   bad_ptr_a: assert property (fin && ins.opcode[7:1] == xor_nibble_pkg::OP_XOR_IND_HI && !ind_ok
      |=> acc == ($past(acc) ^ xor_nibble_pkg::UNDEF_DATA)) else $error("bad pointer");
   one_cycle_a: assert property (fin |=> state == xor_nibble_pkg::ST_IDLE)
      else $error("one cycle timing");
   flags_kept_a: assert property (busy && !(dir_wr && dir_wa == xor_nibble_pkg::ADDR_STATUS)
      |=> $stable(flag_bits)) else $error("flags changed");

   swap_c: cover property (fin && ins.opcode[7:1] == xor_nibble_pkg::OP_NIBBLE_SWAP_HI);
   port_xor_c: cover property (state == xor_nibble_pkg::ST_EXEC2
      && ins.operand1 == xor_nibble_pkg::ADDR_PORT0);
   bad_ptr_c: cover property (busy && !ind_ok && ins.opcode[7:1] == xor_nibble_pkg::OP_XOR_IND_HI);

endmodule

`default_nettype wire

//--- inc/xor_nibble_pkg.sv
// Shared constants, types and register map of the xor / nibble-exchange execution unit
package xor_nibble_pkg;

   // -----------------------------------------------------------------
   // Register map (byte addresses on the register bus)
   // -----------------------------------------------------------------
   localparam logic [7:0] REG_INSTR = 8'h00;      // Opcode and operand bytes, starts execution
   localparam logic [7:0] REG_ACC = 8'h04;        // Accumulator
   localparam logic [7:0] REG_STATUS_WORD = 8'h08; // Program status word
   localparam logic [7:0] REG_PORT_LATCH = 8'h0C; // First I/O port output latch
   localparam logic [7:0] REG_MEM_ADDR = 8'h10;   // Internal memory window address
   localparam logic [7:0] REG_MEM_DATA = 8'h14;   // Internal memory window data
   localparam logic [7:0] REG_EXEC_STATUS = 8'h18; // Busy and illegal-opcode flags

   // -----------------------------------------------------------------
   // Field positions and reset values
   // -----------------------------------------------------------------
   localparam int PARITY_BIT = 0;        // Parity flag in the status word
   localparam int BANK_LO_BIT = 3;       // bank_select_low
   localparam int BANK_HI_BIT = 4;       // bank_select_high
   localparam int BUSY_BIT = 0;          // Execution status: busy
   localparam int ILLEGAL_BIT = 1;       // Execution status: sticky illegal opcode
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] LATCH_RESET = 8'hFF;
   localparam logic [7:0] UNDEF_DATA = 8'hFF; // Returned by out-of-range indirect reads

   // -----------------------------------------------------------------
   // Direct address space
   // -----------------------------------------------------------------
   localparam logic [7:0] SFR_BASE = 8'h80;      // Below this is internal memory
   localparam logic [7:0] ADDR_PORT0 = 8'h90;    // First I/O port
   localparam logic [7:0] ADDR_STATUS = 8'hD0;   // Status word
   localparam logic [7:0] ADDR_ACC = 8'hE0;      // Accumulator

   // -----------------------------------------------------------------
   // Opcodes
   // -----------------------------------------------------------------
   localparam logic [6:0] OP_NIBBLE_SWAP_HI = 7'h6B; // low_nibble_swap_op, top seven bits
   localparam logic [7:0] OP_XOR_DIR_ACC = 8'h62;    // bitwise_xor_op direct <- acc
   localparam logic [7:0] OP_XOR_DIR_IMM = 8'h63;    // bitwise_xor_op direct <- immediate
   localparam logic [7:0] OP_XOR_IMM = 8'h64;        // bitwise_xor_op acc <- immediate
   localparam logic [7:0] OP_XOR_DIR = 8'h65;        // bitwise_xor_op acc <- direct
   localparam logic [6:0] OP_XOR_IND_HI = 7'h33;     // bitwise_xor_op acc <- indirect
   localparam logic [4:0] OP_XOR_REG_HI = 5'h0D;     // bitwise_xor_op acc <- working reg

   // -----------------------------------------------------------------
   // Bus responses
   // -----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] operand2; // Third instruction byte
      logic [7:0] operand1; // Second instruction byte
      logic [7:0] opcode;   // First instruction byte
   } instr_s;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_EXEC2 = 2'b10
   } exec_state_e;

endpackage

//--- verification/xor_and_nibble_exchange_exec_bench.sv
// Self-checking bench for the xor and low-nibble exchange execution unit
`timescale 1ns/1ps
`default_nettype none
module xor_and_nibble_exchange_exec_bench;
   // ---------------------------------------------
   // Signals, clock and notes of expected reads
   // ---------------------------------------------
   logic core_clk = 0, reset_n = 0;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [7:0] port_pins = 8'h00, port_out, acc, sw, v, d;
   logic [33:0] notes[$]; // {resp, data} of each read, oldest first
   int fail_count = 0, n_compared = 0;
   always #12.5 core_clk = ~core_clk;
   xor_nibble_exec uut (.core_clk(core_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .port_pins(port_pins), .port_out(port_out));
   // Verdict and end of run, also reached when a wait runs out
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic bad(input string msg);
      fail_count++;
      $display("BAD %0t %s", $time, msg);
   endtask
   // Bounded wait for a handshake flag, sampled at rising edges
   task automatic await(ref logic flag);
      int n;
      for (n = 0; n < 100 && flag !== 1'b1; n++) @(posedge core_clk);
      if (n == 100) begin
         bad("handshake timeout");
         test_done();
      end
   endtask
   // Register write; address and data offered together, held until taken
   task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] er);
      @(posedge core_clk);
      awaddr <= {24'h0, a};
      wdata <= dt;
      awvalid <= 1;
      wvalid <= 1;
      @(posedge core_clk);
      await(awready);
      awvalid <= 0;
      wvalid <= 0;
      bready <= 1;
      @(posedge core_clk);
      await(bvalid);
      bready <= 0;
      n_compared++;
      if (bresp !== er) bad("write response");
   endtask
   // Register read; the expectation is noted before the request goes out
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      notes.push_back({er, 24'h0, e});
      @(posedge core_clk);
      araddr <= {24'h0, a};
      arvalid <= 1;
      rready <= 1;
      @(posedge core_clk);
      await(arready);
      arvalid <= 0;
      @(posedge core_clk);
      await(rvalid);
      rready <= 0;
   endtask
   // Watcher: each read answer is compared with the oldest note
   always @(posedge core_clk) begin
      if (reset_n && rvalid === 1'b1 && rready === 1'b1) begin
         n_compared++;
         if (notes.size() == 0) bad("answer without note");
         else if ({rresp, rdata} !== notes.pop_front()) bad("read data");
      end
   end
   // Memory byte through the window; instruction, then its status read back
   task automatic setm(input logic [7:0] a, input logic [7:0] dt);
      wr(xor_nibble_pkg::REG_MEM_ADDR, {24'h0, a}, xor_nibble_pkg::RESP_OKAY);
      wr(xor_nibble_pkg::REG_MEM_DATA, {24'h0, dt}, xor_nibble_pkg::RESP_OKAY);
   endtask
   task automatic ex(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3);
      wr(xor_nibble_pkg::REG_INSTR, {8'h00, b3, b2, op}, xor_nibble_pkg::RESP_OKAY);
      // Finished and legal by the time the next read is taken
      rd(xor_nibble_pkg::REG_EXEC_STATUS, 8'h00, xor_nibble_pkg::RESP_OKAY);
   endtask
   // Accumulator and status word: stored bits kept, parity follows acc
   task automatic chk(input logic [7:0] e, input string name);
      acc = e;
      rd(xor_nibble_pkg::REG_ACC, e, xor_nibble_pkg::RESP_OKAY);
      rd(xor_nibble_pkg::REG_STATUS_WORD, {sw[7:1], ^e}, xor_nibble_pkg::RESP_OKAY);
      $display("test %s done", name);
   endtask
   task automatic lda();
      acc = 8'($urandom);
      wr(xor_nibble_pkg::REG_ACC, {24'h0, acc}, xor_nibble_pkg::RESP_OKAY);
   endtask
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      sw = 8'h00;
      repeat (6) @(posedge core_clk);
      reset_n <= 1;
      void'($urandom(32'h1a781485));
      rd(xor_nibble_pkg::REG_PORT_LATCH, 8'hFF, xor_nibble_pkg::RESP_OKAY);
      rd(8'h1C, 8'h00, xor_nibble_pkg::RESP_SLVERR);
      wr(8'h1C, 32'h0, xor_nibble_pkg::RESP_SLVERR);
      chk(8'h00, "reset");
      // Nibble exchange through both pointers, memory side read back
      for (int r = 0; r < 2; r++) begin
         v = 8'($urandom);
         setm(8'(r), 8'h52 + 8'(r));
         setm(8'h52 + 8'(r), v);
         lda();
         d = {v[7:4], acc[3:0]};
         ex(8'hD6 | 8'(r), 8'h00, 8'h00);
         rd(xor_nibble_pkg::REG_MEM_DATA, d, xor_nibble_pkg::RESP_OKAY);
         chk({acc[7:4], v[3:0]}, "nibble swap");
         lda();
         ex(8'h66 | 8'(r), 8'h00, 8'h00);
         chk(acc ^ d, "xor indirect");
      end
      // Immediate, direct memory, port pins as source
      lda();
      d = 8'($urandom);
      ex(xor_nibble_pkg::OP_XOR_IMM, d, 8'h00);
      chk(acc ^ d, "xor immediate");
      v = 8'($urandom);
      setm(8'h37, v);
      ex(xor_nibble_pkg::OP_XOR_DIR, 8'h37, 8'h00);
      chk(acc ^ v, "xor direct");
      port_pins <= 8'($urandom);
      ex(xor_nibble_pkg::OP_XOR_DIR, 8'h90, 8'h00);
      chk(acc ^ port_pins, "xor port pins");
      // Read-modify-write on the port latch, two-cycle form
      d = 8'($urandom);
      ex(xor_nibble_pkg::OP_XOR_DIR_IMM, 8'h90, d);
      rd(xor_nibble_pkg::REG_PORT_LATCH, 8'hFF ^ d, xor_nibble_pkg::RESP_OKAY);
      n_compared++;
      if (port_out !== (8'hFF ^ d)) bad("port output");
      chk(acc, "xor immediate to port");
      // Accumulator into a memory byte, accumulator kept
      v = 8'($urandom);
      setm(8'h21, v);
      ex(xor_nibble_pkg::OP_XOR_DIR_ACC, 8'h21, 8'h00);
      rd(xor_nibble_pkg::REG_MEM_DATA, v ^ acc, xor_nibble_pkg::RESP_OKAY);
      chk(acc, "xor accumulator to memory");
      // Unserved opcode sets the sticky flag, a one clears it
      wr(xor_nibble_pkg::REG_INSTR, 32'h0, xor_nibble_pkg::RESP_OKAY);
      rd(xor_nibble_pkg::REG_EXEC_STATUS, 8'h02, xor_nibble_pkg::RESP_OKAY);
      wr(xor_nibble_pkg::REG_EXEC_STATUS, 32'h2, xor_nibble_pkg::RESP_OKAY);
      rd(xor_nibble_pkg::REG_EXEC_STATUS, 8'h00, xor_nibble_pkg::RESP_OKAY);
      $display("test illegal opcode done");
      // Pointer out of range reads the undefined pattern
      setm(8'h00, 8'h80 | 8'($urandom));
      ex(8'h66, 8'h00, 8'h00);
      chk(acc ^ xor_nibble_pkg::UNDEF_DATA, "pointer out of range");
      // Working registers in a random bank, every register
      sw = 8'($urandom) & 8'hFE;
      wr(xor_nibble_pkg::REG_STATUS_WORD, {24'h0, sw}, xor_nibble_pkg::RESP_OKAY);
      for (int n = 0; n < 8; n++) begin
         v = 8'($urandom);
         setm({3'b000, sw[4:3], 3'(n)}, v);
         ex(8'h68 | 8'(n), 8'h00, 8'h00);
         chk(acc ^ v, "xor working register");
      end
      test_done();
   end
endmodule
`default_nettype wire
